//--- common/nor_seq_pkg.sv
// package: command codes, unlock addresses, timing counts and bus carriers of the sequencer
package nor_seq_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned ERASE_WINDOW_US = 50;
  localparam int unsigned SUSPEND_LAT_US = 20;
  localparam int unsigned ERASE_WINDOW_CYC = ERASE_WINDOW_US * CLK_MHZ;
  localparam int unsigned SUSPEND_LAT_CYC = SUSPEND_LAT_US * CLK_MHZ;
  localparam int unsigned ERASE_RUN_CYC = 16'h2000;
  localparam int unsigned PROG_RUN_CYC = 16'h0400;
  localparam int unsigned FAIL_LIMIT_CYC = 16'h8000;
  // unlock addresses and data
  localparam logic [11:0] UNLOCK_ADDR_A = 12'h0555;
  localparam logic [11:0] UNLOCK_ADDR_B = 12'h02AA;
  localparam logic [7:0] UNLOCK_DATA_A = 8'h00AA;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h0055;
  // command codes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h0080;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h0010;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h0030;
  localparam logic [7:0] CMD_SUSPEND = 8'h00B0;
  localparam logic [7:0] CMD_RESUME = 8'h0030;
  localparam logic [7:0] CMD_PROG_SUSPEND = 8'h0051;
  localparam logic [7:0] CMD_PROG_RESUME = 8'h0050;
  localparam logic [7:0] CMD_PROGRAM = 8'h00A0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h0090;
  localparam logic [7:0] CMD_CFI = 8'h0098;
  localparam logic [7:0] CMD_RESET = 8'h00F0;
  // status bit positions
  localparam int unsigned BIT_POLARITY = 7;
  localparam int unsigned BIT_TOGGLE = 6;
  localparam int unsigned BIT_TIMEOUT = 5;
  localparam int unsigned BIT_WINDOW = 3;
  localparam int unsigned BIT_SECT_TOG = 2;
  localparam int unsigned BIT_ABORT = 1;
  // manufacturer code (value is arbitrary)
  localparam logic [7:0] MFR_CODE_DEFAULT = 8'h005A;
  localparam int unsigned SECT_BITS = 4;
  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [SECT_BITS-1:0] sector;
    logic [7:0] data;
  } host_cycle_t;
endpackage

//--- design/sector_mark_mem.sv
// small memory: one mark bit per sector for sectors queued for erase
`timescale 1ns/100ps
module sector_mark_mem #(
  parameter int unsigned SECTORS = 16
) (
  input wire logic mclk_i, // system clock
  input wire logic sys_rst_i, // synchronous reset
  input wire logic clear_i, // clear all marks
  input wire logic set_i, // set the mark of set_sect_i
  input wire logic [$clog2(SECTORS)-1:0] set_sect_i, // sector to mark
  input wire logic [$clog2(SECTORS)-1:0] rd_sect_i, // sector to look up
  output logic rd_mark_o // mark of rd_sect_i, same cycle
);
  localparam int unsigned SW = $clog2(SECTORS);
  logic [SECTORS-1:0] marks;
  // one flop per sector; the command that starts a new list also marks its own sector,
  // so the set must win over the clear of the list
  genvar g;
  generate
    for (g = 0; g < SECTORS; g++)
    begin : g_mark
      always_ff @(posedge mclk_i)
      begin
        if (sys_rst_i)
          marks[g] <= 1'b0;
        else if (set_i && set_sect_i == SW'(g))
          marks[g] <= 1'b1;
        else if (clear_i)
          marks[g] <= 1'b0;
      end
    end
  endgenerate
  // lookup in the read cycle itself: the status-or-array choice is made there, and a
  // register here would answer for the sector of the previous bus cycle
  assign rd_mark_o = marks[rd_sect_i];
endmodule

//--- design/nor_erase_suspend_autoselect_ctrl.sv
// command sequencer: erase, suspend/resume, buffer abort status, automatic select, reset
`timescale 1ns/100ps
module nor_erase_suspend_autoselect_ctrl #(
  parameter int unsigned SECTORS = 16,
  parameter logic [7:0] MFR_CODE = nor_seq_pkg::MFR_CODE_DEFAULT, // arbitrary value
  parameter int unsigned ERASE_RUN = nor_seq_pkg::ERASE_RUN_CYC,
  parameter int unsigned PROG_RUN = nor_seq_pkg::PROG_RUN_CYC,
  parameter int unsigned FAIL_LIMIT = nor_seq_pkg::FAIL_LIMIT_CYC
) (
  input wire logic mclk_i, // 40 MHz clock
  input wire logic sys_rst_i, // synchronous reset, also the hardware reset
  input wire nor_seq_pkg::host_cycle_t cyc_i, // host write/read cycle
  input wire logic [7:0] array_data_i, // array data for the read address
  input wire logic buf_abort_i, // buffer write abort event
  input wire logic fail_inject_i, // forces the running operation to exceed its limit
  input wire logic address_bit_nine_hv_i, // high voltage on address bit nine (pin)
  output logic [7:0] rd_data_o, // read data, one cycle after the read strobe
  output logic ready_busy_n_o, // ready/busy level, high when ready
  output logic ready_busy_oe_n_o, // open-drain enable, low while pulling low
  output logic erase_susp_o // erase-suspended read mode indicator
);
  typedef enum {ST_READ, ST_ERASE_WIN, ST_ERASING, ST_SUSP_WAIT, ST_ERASE_SUSP,
                ST_PROGRAM, ST_PROG_SUSP, ST_AUTOSEL, ST_CFI, ST_FAIL} mode_t;
  typedef enum {SQ_IDLE, SQ_U1, SQ_U2, SQ_SETUP, SQ_U3, SQ_U4, SQ_PROG} seq_t;
  localparam int unsigned SW = $clog2(SECTORS);

  mode_t mode, next_mode, ret_mode, next_ret_mode;
  seq_t seq, next_seq;
  logic [15:0] timer, next_timer;
  logic [15:0] age;
  logic chip_erase, next_chip_erase;
  logic prog_d7;
  logic toggle_flag, sect_toggle;
  logic abort_flag;
  logic hv_meta, hv_sync, hv_prev;
  logic susp_flag;
  logic mark_rd;

  // ----------------------------------------------------------------
  // pin synchroniser for the high-voltage detect
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      hv_meta <= 1'b0;
      hv_sync <= 1'b0;
      hv_prev <= 1'b0;
    end
    else
    begin
      hv_meta <= address_bit_nine_hv_i;
      hv_sync <= hv_meta;
      hv_prev <= hv_sync;
    end
  end
  wire hv_rise = hv_sync && !hv_prev;
  wire hv_fall = !hv_sync && hv_prev;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire wr = cyc_i.we;
  wire [7:0] wd = cyc_i.data;
  wire is_unlock_a = wr && cyc_i.addr == nor_seq_pkg::UNLOCK_ADDR_A
                     && wd == nor_seq_pkg::UNLOCK_DATA_A;
  wire is_unlock_b = wr && cyc_i.addr == nor_seq_pkg::UNLOCK_ADDR_B
                     && wd == nor_seq_pkg::UNLOCK_DATA_B;
  wire is_reset = wr && wd == nor_seq_pkg::CMD_RESET;
  wire is_susp = wr && wd == nor_seq_pkg::CMD_SUSPEND;
  wire is_resume = wr && wd == nor_seq_pkg::CMD_RESUME;
  wire is_psusp = wr && wd == nor_seq_pkg::CMD_PROG_SUSPEND;
  wire is_presume = wr && wd == nor_seq_pkg::CMD_PROG_RESUME;
  wire is_cfi = wr && wd == nor_seq_pkg::CMD_CFI;
  // modes that take unlock sequences at all
  wire seq_mode = mode == ST_READ || mode == ST_ERASE_SUSP || mode == ST_PROG_SUSP
                  || mode == ST_CFI || mode == ST_ERASE_WIN;
  wire active = mode == ST_ERASE_WIN || mode == ST_ERASING || mode == ST_SUSP_WAIT
                || mode == ST_PROGRAM;
  // the time limit covers the embedded run only, not the collection window
  wire timed = mode == ST_ERASING || mode == ST_SUSP_WAIT || mode == ST_PROGRAM;
  // status-reading cycle: any read while busy or failed, or a read of a suspended-erase sector
  wire rd_status = cyc_i.re && (active || mode == ST_FAIL
                   || (mode == ST_ERASE_SUSP && mark_rd));

  sector_mark_mem #(.SECTORS(SECTORS)) u_marks (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(mode == ST_READ && seq == SQ_U4 && wr && wd == nor_seq_pkg::CMD_SECTOR_ERASE),
    .set_i(seq == SQ_U4 && wr && wd == nor_seq_pkg::CMD_SECTOR_ERASE
           && (mode == ST_READ || mode == ST_ERASE_WIN)),
    .set_sect_i(cyc_i.sector[SW-1:0]),
    .rd_sect_i(cyc_i.sector[SW-1:0]),
    .rd_mark_o(mark_rd)
  );

  // ----------------------------------------------------------------
  // unlock sequence tracker
  // ----------------------------------------------------------------
  always_comb
  begin
    next_seq = seq;
    if (!seq_mode)
      next_seq = SQ_IDLE;
    else if (wr)
    begin
      unique case (seq)
        SQ_IDLE: next_seq = is_unlock_a ? SQ_U1 : SQ_IDLE;
        SQ_U1: next_seq = is_unlock_b ? SQ_U2 : SQ_IDLE;
        SQ_U2: next_seq = wd == nor_seq_pkg::CMD_ERASE_SETUP ? SQ_SETUP
                        : wd == nor_seq_pkg::CMD_PROGRAM ? SQ_PROG : SQ_IDLE;
        SQ_SETUP: next_seq = is_unlock_a ? SQ_U3 : SQ_IDLE;
        SQ_U3: next_seq = is_unlock_b ? SQ_U4 : SQ_IDLE;
        SQ_U4: next_seq = SQ_IDLE;
        SQ_PROG: next_seq = SQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    next_ret_mode = ret_mode;
    next_timer = (timer != 16'h0000) ? timer - 16'h0001 : timer;
    next_chip_erase = chip_erase;
    unique case (mode)
      ST_READ, ST_ERASE_SUSP, ST_PROG_SUSP, ST_CFI:
      begin
        if (hv_rise)
        begin
          next_ret_mode = (mode == ST_ERASE_SUSP) ? ST_ERASE_SUSP : ST_READ;
          next_mode = ST_AUTOSEL;
        end
        else if (is_reset && seq != SQ_U4 && (mode == ST_CFI || seq != SQ_IDLE))
          next_mode = (mode == ST_CFI) ? ST_READ : mode;
        else if (seq == SQ_U2 && wr && wd == nor_seq_pkg::CMD_AUTOSEL)
        begin
          next_ret_mode = (mode == ST_CFI) ? ST_READ : mode;
          next_mode = ST_AUTOSEL;
        end
        else if (mode == ST_READ && seq == SQ_U4 && wr && wd == nor_seq_pkg::CMD_CHIP_ERASE)
        begin
          next_chip_erase = 1'b1;
          next_timer = 16'(ERASE_RUN);
          next_mode = ST_ERASING;
        end
        else if (mode == ST_READ && seq == SQ_U4 && wr
                 && wd == nor_seq_pkg::CMD_SECTOR_ERASE)
        begin
          next_chip_erase = 1'b0;
          next_timer = 16'(nor_seq_pkg::ERASE_WINDOW_CYC);
          next_mode = ST_ERASE_WIN;
        end
        else if (mode != ST_PROG_SUSP && mode != ST_CFI && seq == SQ_PROG && wr)
        begin
          next_ret_mode = mode; // program from read or erase suspend
          next_chip_erase = 1'b0; // failure status must read as a program
          next_timer = 16'(PROG_RUN);
          next_mode = ST_PROGRAM;
        end
        else if (mode == ST_ERASE_SUSP && seq == SQ_IDLE && is_resume)
        begin
          next_timer = 16'(ERASE_RUN);
          next_mode = ST_ERASING;
        end
        else if (mode == ST_PROG_SUSP && seq == SQ_IDLE && is_presume)
        begin
          next_timer = 16'(PROG_RUN);
          next_mode = ST_PROGRAM;
        end
        else if (mode == ST_READ && seq == SQ_IDLE && is_cfi)
          next_mode = ST_CFI;
        // erases and program suspend in suspend modes fall through unused
      end
      ST_ERASE_WIN:
      begin
        if (is_susp)
          next_mode = ST_ERASE_SUSP;
        else if (seq == SQ_U4 && wr && wd == nor_seq_pkg::CMD_SECTOR_ERASE)
          next_timer = 16'(nor_seq_pkg::ERASE_WINDOW_CYC);
        else if (wr && seq == SQ_IDLE && !is_unlock_a)
          next_mode = ST_READ; // other command aborts the window
        else if (timer == 16'h0000)
        begin
          next_timer = 16'(ERASE_RUN);
          next_mode = ST_ERASING;
        end
      end
      ST_ERASING:
      begin
        if (fail_inject_i || age == 16'(FAIL_LIMIT))
          next_mode = ST_FAIL;
        else if (timer == 16'h0000)
          next_mode = ST_READ;
        else if (is_susp && !chip_erase)
        begin
          next_ret_mode = ST_ERASING;
          next_timer = 16'(nor_seq_pkg::SUSPEND_LAT_CYC);
          next_mode = ST_SUSP_WAIT;
        end
        // other commands, reset included, are ignored here
      end
      ST_SUSP_WAIT:
        if (timer == 16'h0000)
          next_mode = ST_ERASE_SUSP;
      ST_PROGRAM:
      begin
        if (fail_inject_i || age == 16'(FAIL_LIMIT))
          next_mode = ST_FAIL;
        else if (buf_abort_i)
          next_mode = ST_FAIL;
        else if (timer == 16'h0000)
          next_mode = ret_mode;
        else if (is_psusp && ret_mode == ST_READ)
          next_mode = ST_PROG_SUSP;
      end
      ST_AUTOSEL:
      begin
        if (is_reset || hv_fall)
        begin
          next_mode = ret_mode;
          next_ret_mode = ST_READ; // a later resumed program must end in read mode
        end
      end
      ST_FAIL:
        if (is_reset)
          next_mode = ST_READ;
      default: next_mode = ST_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      mode <= ST_READ; // hardware reset stops any operation
      ret_mode <= ST_READ;
      seq <= SQ_IDLE;
      timer <= 16'h0000;
      chip_erase <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      ret_mode <= next_ret_mode;
      seq <= next_seq;
      timer <= next_timer;
      chip_erase <= next_chip_erase;
    end
  end

  // age of the running operation for the time limit; abort flag sticks until reset
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || !timed)
      age <= 16'h0000;
    else if (age != 16'hFFFF)
      age <= age + 16'h0001;
    if (sys_rst_i || (mode == ST_FAIL && is_reset))
      abort_flag <= 1'b0;
    else if (mode == ST_PROGRAM && buf_abort_i)
      abort_flag <= 1'b1;
    if (sys_rst_i)
      prog_d7 <= 1'b0;
    else if (seq == SQ_PROG && wr)
      prog_d7 <= wd[7]; // polarity reference for program status
  end

  // toggle bits advance only on status reads; in erase suspend only the sector toggle advances
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      toggle_flag <= 1'b0;
      sect_toggle <= 1'b0;
    end
    else if (rd_status)
    begin
      if (mode != ST_ERASE_SUSP)
        toggle_flag <= !toggle_flag;
      sect_toggle <= !sect_toggle;
    end
  end

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  wire prog_like = mode == ST_PROGRAM || (mode == ST_FAIL && !chip_erase);
  wire timeout_fail_flag = mode == ST_FAIL && !abort_flag;
  logic [7:0] status_word;
  always_comb
  begin
    status_word = 8'h0000;
    if (mode == ST_ERASE_SUSP)
    begin
      status_word[nor_seq_pkg::BIT_POLARITY] = 1'b1;
      status_word[nor_seq_pkg::BIT_TOGGLE] = toggle_flag;
      status_word[nor_seq_pkg::BIT_SECT_TOG] = !sect_toggle;
    end
    else
    begin
      status_word[nor_seq_pkg::BIT_POLARITY] = prog_like ? !prog_d7 : 1'b0;
      status_word[nor_seq_pkg::BIT_TOGGLE] = !toggle_flag;
      status_word[nor_seq_pkg::BIT_TIMEOUT] = timeout_fail_flag;
      status_word[nor_seq_pkg::BIT_WINDOW] = mode != ST_ERASE_WIN && !prog_like;
      status_word[nor_seq_pkg::BIT_SECT_TOG] = prog_like ? 1'b0 : !sect_toggle;
      status_word[nor_seq_pkg::BIT_ABORT] = abort_flag;
    end
  end
  wire autosel_mfr = cyc_i.addr[1:0] == 2'b00;
  wire [7:0] next_rd = !cyc_i.re ? 8'h0000
                     : rd_status ? status_word
                     : mode == ST_AUTOSEL ? (autosel_mfr ? MFR_CODE : 8'h0000)
                     : array_data_i;
  // busy low during any embedded operation; suspended modes read ready
  wire next_busy_n = !(active || mode == ST_FAIL);

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= 8'h0000;
      ready_busy_n_o <= 1'b1;
      ready_busy_oe_n_o <= 1'b1;
      erase_susp_o <= 1'b0;
      susp_flag <= 1'b0;
    end
    else
    begin
      rd_data_o <= next_rd;
      ready_busy_n_o <= next_busy_n;
      ready_busy_oe_n_o <= next_busy_n;
      erase_susp_o <= next_mode == ST_ERASE_SUSP;
      susp_flag <= mode == ST_ERASE_SUSP;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_busy_low_active: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_ERASING) |=> !ready_busy_n_o)
    else $error("busy not low during erase");
  a_window_suspend: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_ERASE_WIN && is_susp) |=> mode == ST_ERASE_SUSP)
    else $error("window suspend not immediate");
  a_suspend_latency: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_ERASING && next_mode == ST_SUSP_WAIT) |=> mode == ST_SUSP_WAIT [*8])
    else $error("erase suspend too early");
  a_chip_no_cmd: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_ERASING && chip_erase && is_reset && timer != 16'h0000 && !fail_inject_i
     && age != 16'(FAIL_LIMIT)) |=> mode == ST_ERASING)
    else $error("chip erase took a command");
  a_autosel_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_AUTOSEL && is_reset) |=> mode == $past(ret_mode))
    else $error("autoselect reset went wrong");
  a_mfr_code: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_AUTOSEL && cyc_i.re && autosel_mfr) |=> rd_data_o == MFR_CODE)
    else $error("manufacturer code wrong");
  a_toggle_reads: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_status && mode == ST_ERASING) |=> toggle_flag != $past(toggle_flag))
    else $error("toggle flag did not toggle");
  a_fail_sticks: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode == ST_FAIL && !is_reset) |=> mode == ST_FAIL)
    else $error("failure left without reset");
  a_susp_ready: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    susp_flag |-> ready_busy_n_o)
    else $error("busy low in erase suspend");
  c_chip_erase: cover property (@(posedge mclk_i) mode == ST_ERASING && chip_erase);
  c_erase_susp: cover property (@(posedge mclk_i) mode == ST_ERASE_SUSP);
  c_autosel: cover property (@(posedge mclk_i) mode == ST_AUTOSEL);
  c_prog_susp: cover property (@(posedge mclk_i) mode == ST_PROG_SUSP);
endmodule

//--- sim/host_bus_model.sv
// host model: drives command and read cycles, resolves the ready/busy pin
`timescale 1ns/100ps
module host_bus_model (
  input wire logic mclk_i, // system clock
  input wire logic [7:0] rd_data_i, // read data from the device
  input wire logic ready_busy_oe_n_i, // low while the device pulls low
  output nor_seq_pkg::host_cycle_t cyc_o, // cycle to the device
  output logic ready_busy_pin_o // resolved pin level
);
  // open-drain line with pull-up: reads high unless pulled
  assign ready_busy_pin_o = ready_busy_oe_n_i ? 1'b1 : 1'b0;
  initial cyc_o = '0;
  // one write: strobe held for exactly one edge
  task automatic wr(input logic [11:0] a, input logic [3:0] s, input logic [7:0] d);
    @(posedge mclk_i);
    cyc_o <= '{1'b1, 1'b0, a, s, d};
    @(posedge mclk_i);
    cyc_o.we <= 1'b0;
  endtask
  // one read: data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [3:0] s, output logic [7:0] d);
    @(posedge mclk_i);
    cyc_o <= '{1'b0, 1'b1, a, s, 8'h0000};
    @(posedge mclk_i);
    cyc_o.re <= 1'b0;
    #1 d = rd_data_i;
  endtask
  // two unlocks then a command byte, the prefix of every sequence
  task automatic cmd(input logic [7:0] c);
    wr(nor_seq_pkg::UNLOCK_ADDR_A, 4'h0, nor_seq_pkg::UNLOCK_DATA_A);
    wr(nor_seq_pkg::UNLOCK_ADDR_B, 4'h0, nor_seq_pkg::UNLOCK_DATA_B);
    wr(nor_seq_pkg::UNLOCK_ADDR_A, 4'h0, c);
  endtask
endmodule

//--- sim/tb_top.sv
// testbench: command sequences against the sequencer with status checks
`timescale 1ns/100ps
module tb_top;
  logic mclk_i, sys_rst_i, abrt, fail, hv, rb, oe_n, rbn, susp;
  logic [7:0] rdat, d, p;
  nor_seq_pkg::host_cycle_t cyc;
  int n_errors = 0;
  int compares = 0;
  localparam logic [7:0] ARR = 8'h003C;
  localparam logic [7:0] MFR = nor_seq_pkg::MFR_CODE_DEFAULT;
  // short run counts keep the erase tests brief
  nor_erase_suspend_autoselect_ctrl #(.ERASE_RUN(64), .PROG_RUN(16), .FAIL_LIMIT(2000)) uut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cyc_i(cyc), .array_data_i(ARR),
    .buf_abort_i(abrt), .fail_inject_i(fail), .address_bit_nine_hv_i(hv),
    .rd_data_o(rdat), .ready_busy_n_o(rbn), .ready_busy_oe_n_o(oe_n), .erase_susp_o(susp));
  host_bus_model host (.mclk_i(mclk_i), .rd_data_i(rdat), .ready_busy_oe_n_i(oe_n),
    .cyc_o(cyc), .ready_busy_pin_o(rb));
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for a level; a hang shows up in the compare after it
  task automatic wait_for(ref logic sig, input logic lvl, input int n);
    for (int i = 0; i < n && sig !== lvl; i++)
      @(posedge mclk_i);
    #1;
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic prog_then(input logic use_fail);
    host.cmd(nor_seq_pkg::CMD_PROGRAM);
    host.wr(12'h0010, 4'h6, 8'h0012);
    abrt <= !use_fail;
    fail <= use_fail;
    @(posedge mclk_i);
    abrt <= 1'b0;
    fail <= 1'b0;
    host.rd(12'h0010, 4'h6, d);
  endtask
  initial
  begin
    #(25 * 20000);
    n_errors++;
    report_and_stop();
  end
  // -----------------------------------------------------------
  // tests
  // -----------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    abrt = 1'b0;
    fail = 1'b0;
    hv = 1'b0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1 chk(rb, 1'b1);
    chk(susp, 1'b0);
    // chip erase: busy, status toggles, reset ignored, back to array reads
    host.cmd(nor_seq_pkg::CMD_ERASE_SETUP);
    host.cmd(nor_seq_pkg::CMD_CHIP_ERASE);
    wait_for(rb, 1'b0, 4);
    chk(rb, 1'b0);
    chk(rbn, 1'b0);
    host.rd(12'h0000, 4'h0, p);
    host.rd(12'h0000, 4'h0, d);
    chk({d[7], d[5]}, 8'h0000);
    chk({d[6], d[2]}, ~{p[6], p[2]} & 8'h0003);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_RESET);
    #1 chk(rb, 1'b0);
    wait_for(rb, 1'b1, 200);
    chk(rb, 1'b1);
    host.rd(12'h0000, 4'h0, d);
    chk(d, ARR);
    $display("test chip erase done");
    // automatic select, repeated id reads, reset back to array
    host.wr(12'h0055, 4'h0, nor_seq_pkg::CMD_CFI);
    host.cmd(nor_seq_pkg::CMD_AUTOSEL);
    host.rd(12'h0000, 4'h0, d);
    chk(d, MFR);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_PROGRAM);
    host.rd(12'h0100, 4'h2, d);
    chk(d, MFR);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_RESET);
    host.rd(12'h0004, 4'h0, d);
    chk(d, ARR);
    $display("test autoselect done");
    // suspend inside the window, suspended reads, forbidden erase, resume
    host.cmd(nor_seq_pkg::CMD_ERASE_SETUP);
    host.cmd(nor_seq_pkg::CMD_SECTOR_ERASE);
    host.wr(12'h0000, 4'h3, nor_seq_pkg::CMD_SUSPEND);
    wait_for(susp, 1'b1, 4);
    chk(susp, 1'b1);
    host.rd(12'h0000, 4'h0, p);
    host.rd(12'h0000, 4'h0, d);
    chk({d[7], d[6], d[5], d[2]}, {1'b1, p[6], 1'b0, ~p[2]});
    chk(rb, 1'b1);
    host.rd(12'h0000, 4'h5, d);
    chk(d, ARR);
    host.cmd(nor_seq_pkg::CMD_ERASE_SETUP);
    host.cmd(nor_seq_pkg::CMD_CHIP_ERASE);
    #50 chk({susp, rb}, 8'h0003);
    host.cmd(nor_seq_pkg::CMD_AUTOSEL);
    host.rd(12'h0000, 4'h0, d);
    chk(d, MFR);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_RESET);
    #50 chk(susp, 1'b1);
    // host resumes and lets the erase finish before any new erase
    host.wr(12'h0000, 4'h3, nor_seq_pkg::CMD_RESUME);
    wait_for(susp, 1'b0, 4);
    chk(susp, 1'b0);
    wait_for(rb, 1'b1, 2200);
    chk(rb, 1'b1);
    $display("test window suspend done");
    // suspend once the erase runs: 800 cycles before suspended mode
    host.cmd(nor_seq_pkg::CMD_ERASE_SETUP);
    host.cmd(nor_seq_pkg::CMD_SECTOR_ERASE);
    repeat (2020) @(posedge mclk_i);
    host.wr(12'h0000, 4'h4, nor_seq_pkg::CMD_SUSPEND);
    repeat (780) @(posedge mclk_i);
    chk(susp, 1'b0);
    wait_for(susp, 1'b1, 40);
    chk(susp, 1'b1);
    host.wr(12'h0000, 4'h4, nor_seq_pkg::CMD_RESUME);
    wait_for(rb, 1'b0, 4);
    chk(rb, 1'b0);
    wait_for(rb, 1'b1, 300);
    chk(rb, 1'b1);
    $display("test late suspend done");
    // buffer abort and time-limit failure, both left by reset
    prog_then(1'b0);
    chk({d[7], d[5], d[1], rb}, 8'h000A);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_RESET);
    wait_for(rb, 1'b1, 4);
    chk(rb, 1'b1);
    prog_then(1'b1);
    chk({d[7], d[5], rb}, 8'h0006);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_RESET);
    wait_for(rb, 1'b1, 4);
    chk(rb, 1'b1);
    $display("test failures done");
    // program suspend: ready while suspended, array reads, resume runs to the end
    host.cmd(nor_seq_pkg::CMD_PROGRAM);
    host.wr(12'h0020, 4'h1, 8'h0034);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_PROG_SUSPEND);
    wait_for(rb, 1'b1, 4);
    chk(rb, 1'b1);
    host.rd(12'h0000, 4'h2, d);
    chk(d, ARR);
    host.wr(12'h0000, 4'h0, nor_seq_pkg::CMD_PROG_RESUME);
    wait_for(rb, 1'b0, 4);
    chk(rb, 1'b0);
    wait_for(rb, 1'b1, 40);
    chk(rb, 1'b1);
    $display("test program suspend done");
    // high voltage on address bit nine selects identification reads
    @(posedge mclk_i) hv <= 1'b1;
    repeat (4) @(posedge mclk_i);
    host.rd(12'h0000, 4'h0, d);
    chk(d, MFR);
    @(posedge mclk_i) hv <= 1'b0;
    repeat (4) @(posedge mclk_i);
    host.rd(12'h0000, 4'h0, d);
    chk(d, ARR);
    $display("test id pin done");
    report_and_stop();
  end
endmodule
